// ---- rtl/ivf_pkg.sv ----
package ivf_pkg;

  // ----------------------------------------------------------------
  // host serial port framing
  // ----------------------------------------------------------------
  localparam int SPI_ADDR_BITS = 6;
  localparam int SPI_DATA_BITS = 24;
  localparam logic [4:0] SPI_ADDR_DONE_CNT = 5'h06;
  localparam logic [4:0] SPI_LAST_CNT = 5'h1e;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_DIV_INT = 6'h03;
  localparam logic [5:0] REG_DIV_FRAC = 6'h04;
  localparam logic [5:0] REG_FWD = 6'h05;
  localparam logic [5:0] REG_CAL_CFG = 6'h0a;
  localparam logic [5:0] REG_BAND_RB = 6'h10;
  localparam int CAL_DIS_BIT = 11;
  localparam int CAL_RATE_LSB = 13;
  localparam logic [23:0] CAL_CFG_RESET = 24'h000000;
  localparam logic [23:0] DIV_RESET = 24'h000000;
  localparam logic [15:0] FWD_RESET = 16'h0000;
  localparam logic [7:0] BAND_RB_RESET = 8'h00;

  // ----------------------------------------------------------------
  // internal oscillator link
  // ----------------------------------------------------------------
  localparam logic [4:0] PKT_LAST_CNT = 5'h10;
  localparam logic [3:0] RX_LAST_CNT = 4'hf;
  localparam logic [2:0] TARGET_OSC = 3'h0;
  localparam logic [3:0] OSC_BAND_IDX = 4'h0;
  localparam logic [3:0] OSC_DIV_IDX = 4'h2;
  localparam int OSC_CAL_BIT = 7;
  localparam logic [2:0] DIV_CODE_BY2 = 3'h6;
  localparam logic [2:0] DIV_CODE_BYPASS = 3'h0;
  localparam logic [8:0] OSC_REG_RESET = 9'h000;

  // ----------------------------------------------------------------
  // calibration timing
  // ----------------------------------------------------------------
  localparam int SEARCH_BITS = 6;
  localparam int CAL_SETTLE_NS = 2000;
  localparam int LINK_PERIOD_NS = 125;
  localparam int CAL_SETTLE_CYC = (CAL_SETTLE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [4:0] CAL_SETTLE_LAST = 5'(CAL_SETTLE_CYC - 1);

  typedef struct packed {
    logic [8:0] payload;
    logic [3:0] index;
    logic [2:0] target;
  } ivf_packet_type;

  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_SEND = 4'b0010,
    CAL_WAIT = 4'b0100,
    CAL_SETTLE = 4'b1000
  } ivf_cal_state_type;

  // band code sits around the calibration flag in oscillator register zero
  function automatic logic [8:0] band_to_payload(input logic [5:0] band, input logic cal);
    band_to_payload = {band[5], cal, 1'b0, band[4:0], 1'b0};
  endfunction

  function automatic logic [7:0] payload_to_readback(input logic [8:0] p);
    payload_to_readback = {p[8], p[7], 1'b0, p[5:1]};
  endfunction

  function automatic logic [2:0] rate_mask(input logic [1:0] r);
    case (r)
      2'h0: rate_mask = 3'h0;
      2'h1: rate_mask = 3'h1;
      2'h2: rate_mask = 3'h3;
      default: rate_mask = 3'h7;
    endcase
  endfunction

endpackage

// ---- rtl/ivf_osc_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module ivf_osc_mem import ivf_pkg::*; #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk, // link clock
  input wire logic rst_n, // async reset, active low
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write index
  input wire logic [WIDTH-1:0] wdata, // write data
  input wire logic [AW-1:0] raddr, // read index
  output logic [WIDTH-1:0] rdata_q // registered read data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // reset keeps the decoded outputs defined before any packet lands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= WIDTH'(OSC_REG_RESET);
      end
      rdata_q <= WIDTH'(OSC_REG_RESET);
    end else begin
      if (we) begin
        mem_q[waddr] <= wdata;
      end
      rdata_q <= mem_q[raddr];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ivf_forwarder.sv ----
//Contract
//- divider and config writes apply at once; oscillator writes go only through forwarding
//- oscillator registers have no read path; band readable via readback register
//- link packets are exactly sixteen bits
//- link runs at calibration clock rate chosen by two config bits, max 50 MHz
//- each forwarding write sends its sixteen bits to the oscillator, MSB first
//- packet: low three bits target, next four index, top nine payload
//- calibration writes go to target and index held in forwarding register
//- calibration only takes effect while stored target is zero
//- correct calibration needs low seven forwarding bits zero
//- integer mode: integer divider write triggers calibration; write it last
//- fractional mode: fractional divider write triggers calibration; write it last
//- skipping band restore and address clearing loses lock
//- all-zero forwarding write then divider rewrite forces a relock
//- payload 0110b into oscillator register two selects divide by two
//- single-ended output always doubled; differential doubled on bypass, fundamental on two
//- calibration machine enabled while config bit eleven is zero
//- band search sets oscillator register zero bit seven, clears it when done
`timescale 1ns/1ps
`default_nettype none
module ivf_forwarder import ivf_pkg::*; (
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic link_clk, // calibration machine clock
  input wire logic spi_sclk, // host serial clock pin
  input wire logic spi_sel_n, // host select pin, active low
  input wire logic spi_sdi, // host serial data in
  output logic spi_sdo, // serial read data
  output logic spi_sdo_oe, // read data drive enable
  input wire logic frac_mode, // high selects fractional mode
  input wire logic vco_above_target, // band comparator, high when trial band too high
  output logic link_frame, // internal link packet frame
  output logic link_data, // internal link serial data
  output logic [2:0] out_div_code, // output divider code
  output logic diff_out_fundamental, // differential carries fundamental
  output logic diff_out_doubled, // differential carries doubled frequency
  output logic doubled_single_ended_output, // single-ended carries doubled frequency
  output logic calibration_tune_reference // tuning port switched to reference
);
  // ----------------------------------------------------------------
  // pin and crossing synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_s, sel_s, ack_s, band_s;
  logic [1:0] sdi_s, frac_s, dis_s, above_s;
  logic [2:0] req_s, cal_s;
  logic [1:0] rate_s0, rate_s1;
  logic ack_tog_q, band_tog_q, req_tog_q, cal_tog_q;
  logic [23:0] cal_cfg_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 3'h0; sel_s <= 3'h7; ack_s <= 3'h0; band_s <= 3'h0;
      sdi_s <= 2'h0; frac_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_sclk}; sel_s <= {sel_s[1:0], spi_sel_n};
      ack_s <= {ack_s[1:0], ack_tog_q}; band_s <= {band_s[1:0], band_tog_q};
      sdi_s <= {sdi_s[0], spi_sdi}; frac_s <= {frac_s[0], frac_mode};
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s <= 3'h0; cal_s <= 3'h0; dis_s <= 2'h0; above_s <= 2'h0;
      rate_s0 <= 2'h0; rate_s1 <= 2'h0;
    end else begin
      req_s <= {req_s[1:0], req_tog_q}; cal_s <= {cal_s[1:0], cal_tog_q};
      dis_s <= {dis_s[0], cal_cfg_q[CAL_DIS_BIT]}; above_s <= {above_s[0], vco_above_target};
      rate_s0 <= cal_cfg_q[CAL_RATE_LSB +: 2]; rate_s1 <= rate_s0;
    end
  end

  // ----------------------------------------------------------------
  // host serial slave
  // ----------------------------------------------------------------
  logic [4:0] spi_cnt_q, spi_cnt_d;
  logic [29:0] spi_sh_q, spi_sh_d;
  logic [23:0] rd_sh_q, rd_sh_d, rword, div_int_q, div_frac_q;
  logic sdo_q, sdo_d, oe_q, oe_d, rd_mode_q, rd_mode_d, wr_stb;
  logic [5:0] rd_addr, wr_addr;
  logic [23:0] wr_data;
  logic [7:0] band_rb_q;
  logic sclk_rise;

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign rd_addr = {spi_sh_q[4:0], sdi_s[1]};

  always_comb begin
    rword = 24'h000000;
    if (rd_addr == REG_DIV_INT) begin
      rword = div_int_q;
    end else if (rd_addr == REG_DIV_FRAC) begin
      rword = div_frac_q;
    end else if (rd_addr == REG_CAL_CFG) begin
      rword = cal_cfg_q;
    end else if (rd_addr == REG_BAND_RB) begin
      rword = {16'h0000, band_rb_q};
    end
  end

  always_comb begin
    spi_cnt_d = spi_cnt_q; spi_sh_d = spi_sh_q; rd_sh_d = rd_sh_q;
    sdo_d = sdo_q; oe_d = oe_q; rd_mode_d = rd_mode_q;
    wr_stb = 1'b0; wr_addr = spi_sh_q[28:23]; wr_data = {spi_sh_q[22:0], sdi_s[1]};
    if (sel_s[1]) begin
      spi_cnt_d = 5'h00; oe_d = 1'b0; rd_mode_d = 1'b0; sdo_d = 1'b0;
    end else if (sclk_rise && spi_cnt_q <= SPI_LAST_CNT) begin
      spi_sh_d = {spi_sh_q[28:0], sdi_s[1]};
      spi_cnt_d = spi_cnt_q + 5'h01;
      if (spi_cnt_q == SPI_ADDR_DONE_CNT && spi_sh_q[5]) begin
        rd_mode_d = 1'b1; oe_d = 1'b1;
        sdo_d = rword[23]; rd_sh_d = {rword[22:0], 1'b0};
      end else if (rd_mode_q) begin
        sdo_d = rd_sh_q[23]; rd_sh_d = {rd_sh_q[22:0], 1'b0};
      end
      wr_stb = (spi_cnt_q == SPI_LAST_CNT) && !spi_sh_q[29];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_cnt_q <= 5'h00; spi_sh_q <= 30'h0; rd_sh_q <= 24'h0;
      sdo_q <= 1'b0; oe_q <= 1'b0; rd_mode_q <= 1'b0;
    end else begin
      spi_cnt_q <= spi_cnt_d; spi_sh_q <= spi_sh_d; rd_sh_q <= rd_sh_d;
      sdo_q <= sdo_d; oe_q <= oe_d; rd_mode_q <= rd_mode_d;
    end
  end
  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = oe_q;

  // ----------------------------------------------------------------
  // synthesizer registers and forwarding queue
  // ----------------------------------------------------------------
  logic [23:0] div_int_d, div_frac_d, cal_cfg_d;
  logic [15:0] stage_q, stage_d, next_q, next_d;
  logic next_v_q, next_v_d, inflight_q, inflight_d, req_tog_d, cal_tog_d;
  logic [7:0] band_rb_d;
  logic ack_edge;
  logic [8:0] band_hold_q;

  assign ack_edge = ack_s[1] ^ ack_s[2];

  always_comb begin
    div_int_d = div_int_q; div_frac_d = div_frac_q; cal_cfg_d = cal_cfg_q;
    stage_d = stage_q; next_d = next_q; next_v_d = next_v_q; inflight_d = inflight_q;
    req_tog_d = req_tog_q; cal_tog_d = cal_tog_q; band_rb_d = band_rb_q;
    if (wr_stb) begin
      if (wr_addr == REG_DIV_INT) begin
        div_int_d = wr_data;
        if (!frac_s[1]) cal_tog_d = ~cal_tog_q;
      end else if (wr_addr == REG_DIV_FRAC) begin
        div_frac_d = wr_data;
        if (frac_s[1]) cal_tog_d = ~cal_tog_q;
      end else if (wr_addr == REG_CAL_CFG) begin
        cal_cfg_d = wr_data;
      end else if (wr_addr == REG_FWD) begin
        next_d = wr_data[15:0];
        next_v_d = 1'b1;
      end
    end
    if (ack_edge) inflight_d = 1'b0;
    // the word in flight stays untouched until the link side acknowledges it
    if ((!inflight_q || ack_edge) && next_v_d) begin
      stage_d = next_d; next_v_d = 1'b0; inflight_d = 1'b1; req_tog_d = ~req_tog_q;
    end
    // band word is stable for many link cycles after its toggle
    if (band_s[1] ^ band_s[2]) band_rb_d = payload_to_readback(band_hold_q);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_int_q <= DIV_RESET; div_frac_q <= DIV_RESET; cal_cfg_q <= CAL_CFG_RESET;
      stage_q <= FWD_RESET; next_q <= FWD_RESET; next_v_q <= 1'b0; inflight_q <= 1'b0;
      req_tog_q <= 1'b0; cal_tog_q <= 1'b0; band_rb_q <= BAND_RB_RESET;
    end else begin
      div_int_q <= div_int_d; div_frac_q <= div_frac_d; cal_cfg_q <= cal_cfg_d;
      stage_q <= stage_d; next_q <= next_d; next_v_q <= next_v_d; inflight_q <= inflight_d;
      req_tog_q <= req_tog_d; cal_tog_q <= cal_tog_d; band_rb_q <= band_rb_d;
    end
  end

  // ----------------------------------------------------------------
  // link transmitter
  // ----------------------------------------------------------------
  logic [2:0] div_cnt_q;
  logic tick, cal_req_q, cal_take, host_take;
  logic [15:0] tx_sh_q, tx_sh_d;
  logic [4:0] tx_cnt_q, tx_cnt_d;
  logic tx_busy_q, tx_busy_d, frame_q, frame_d, data_q, data_d, host_pend_q, host_pend_d, ack_tog_d;
  logic [6:0] fwd_low_q, fwd_low_d;
  ivf_packet_type cal_word_q, cal_word_d;

  assign tick = (div_cnt_q & rate_mask(rate_s1)) == rate_mask(rate_s1);
  assign cal_take = !tx_busy_q && cal_req_q;
  assign host_take = !tx_busy_q && !cal_req_q && host_pend_q;

  always_comb begin
    tx_sh_d = tx_sh_q; tx_cnt_d = tx_cnt_q; tx_busy_d = tx_busy_q; frame_d = frame_q; data_d = data_q;
    host_pend_d = host_pend_q; ack_tog_d = ack_tog_q; fwd_low_d = fwd_low_q;
    if (host_take) host_pend_d = 1'b0;
    if (req_s[1] ^ req_s[2]) host_pend_d = 1'b1;
    if (cal_take) begin
      tx_sh_d = cal_word_q; tx_busy_d = 1'b1; tx_cnt_d = 5'h00;
    end else if (host_take) begin
      tx_sh_d = stage_q; fwd_low_d = stage_q[6:0];
      tx_busy_d = 1'b1; tx_cnt_d = 5'h00; ack_tog_d = ~ack_tog_q;
    end else if (tx_busy_q && tick) begin
      if (tx_cnt_q == PKT_LAST_CNT) begin
        tx_busy_d = 1'b0; frame_d = 1'b0;
      end else begin
        frame_d = 1'b1; data_d = tx_sh_q[15];
        tx_sh_d = {tx_sh_q[14:0], 1'b0}; tx_cnt_d = tx_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 3'h0; tx_sh_q <= 16'h0; tx_cnt_q <= 5'h00; tx_busy_q <= 1'b0; frame_q <= 1'b0;
      data_q <= 1'b0; host_pend_q <= 1'b0; ack_tog_q <= 1'b0; fwd_low_q <= 7'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1; tx_sh_q <= tx_sh_d; tx_cnt_q <= tx_cnt_d; tx_busy_q <= tx_busy_d;
      frame_q <= frame_d; data_q <= data_d; host_pend_q <= host_pend_d; ack_tog_q <= ack_tog_d;
      fwd_low_q <= fwd_low_d;
    end
  end
  assign link_frame = frame_q;
  assign link_data = data_q;

  // ----------------------------------------------------------------
  // oscillator side receiver and register decode
  // ----------------------------------------------------------------
  logic [15:0] rx_sh_q, rx_sh_d;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  logic we_q, we_d, band_tog_d;
  logic [3:0] waddr_q, waddr_d;
  logic [8:0] wdata_q, wdata_d, band_hold_d, mem_rdata;
  ivf_packet_type rx_pkt;

  assign rx_pkt = {rx_sh_q[14:0], data_q};

  always_comb begin
    rx_sh_d = rx_sh_q; rx_cnt_d = rx_cnt_q; we_d = 1'b0; waddr_d = waddr_q; wdata_d = wdata_q;
    band_hold_d = band_hold_q; band_tog_d = band_tog_q;
    if (tick && frame_q) begin
      rx_sh_d = rx_pkt; rx_cnt_d = rx_cnt_q + 4'h1;
      // a foreign target drops the packet, so a stray id silently voids calibration
      if (rx_cnt_q == RX_LAST_CNT && rx_pkt.target == TARGET_OSC) begin
        we_d = 1'b1; waddr_d = rx_pkt.index; wdata_d = rx_pkt.payload;
        if (rx_pkt.index == OSC_BAND_IDX) begin
          band_hold_d = rx_pkt.payload; band_tog_d = ~band_tog_q;
        end
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q <= 16'h0; rx_cnt_q <= 4'h0; we_q <= 1'b0; waddr_q <= 4'h0; wdata_q <= OSC_REG_RESET;
      band_hold_q <= OSC_REG_RESET; band_tog_q <= 1'b0;
    end else begin
      rx_sh_q <= rx_sh_d; rx_cnt_q <= rx_cnt_d; we_q <= we_d; waddr_q <= waddr_d; wdata_q <= wdata_d;
      band_hold_q <= band_hold_d; band_tog_q <= band_tog_d;
    end
  end

  ivf_osc_mem #(.WIDTH(9), .DEPTH(16), .AW(4)) u_osc_mem (
    .clk(link_clk),
    .rst_n(rst_n),
    .we(we_q),
    .waddr(waddr_q),
    .wdata(wdata_q),
    .raddr(OSC_DIV_IDX),
    .rdata_q(mem_rdata)
  );

  // ----------------------------------------------------------------
  // decoded output stage
  // ----------------------------------------------------------------
  logic [2:0] div_code_q;
  logic fund_q, dbl_q, se_q, tune_q;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_code_q <= DIV_CODE_BYPASS; fund_q <= 1'b0; dbl_q <= 1'b1; se_q <= 1'b1; tune_q <= 1'b0;
    end else begin
      div_code_q <= mem_rdata[2:0];
      fund_q <= mem_rdata[2:0] == DIV_CODE_BY2;
      dbl_q <= mem_rdata[2:0] == DIV_CODE_BYPASS;
      se_q <= 1'b1;
      tune_q <= band_hold_q[OSC_CAL_BIT];
    end
  end
  assign out_div_code = div_code_q;
  assign diff_out_fundamental = fund_q;
  assign diff_out_doubled = dbl_q;
  assign doubled_single_ended_output = se_q;
  assign calibration_tune_reference = tune_q;

  // ----------------------------------------------------------------
  // calibration machine
  // ----------------------------------------------------------------
  ivf_cal_state_type cal_st_q, cal_st_d;
  logic [5:0] band_q, band_d, trial;
  logic [2:0] bit_idx_q, bit_idx_d;
  logic [4:0] settle_q, settle_d;
  logic final_q, final_d, cal_req_d;

  assign trial = band_q | (6'h01 << bit_idx_q);

  always_comb begin
    cal_st_d = cal_st_q; band_d = band_q; bit_idx_d = bit_idx_q; settle_d = settle_q;
    final_d = final_q; cal_req_d = cal_req_q; cal_word_d = cal_word_q;
    if (cal_take) cal_req_d = 1'b0;
    case (cal_st_q)
      CAL_IDLE: begin
        if ((cal_s[1] ^ cal_s[2]) && !dis_s[1]) begin
          band_d = 6'h00; bit_idx_d = 3'(SEARCH_BITS - 1); final_d = 1'b0; cal_req_d = 1'b1;
          cal_word_d = {band_to_payload(6'h20, 1'b1), fwd_low_q};
          cal_st_d = CAL_SEND;
        end
      end
      CAL_SEND: begin
        if (cal_take) cal_st_d = CAL_WAIT;
      end
      CAL_WAIT: begin
        if (!tx_busy_q) begin
          settle_d = 5'h00;
          cal_st_d = final_q ? CAL_IDLE : CAL_SETTLE;
        end
      end
      CAL_SETTLE: begin
        settle_d = settle_q + 5'h01;
        if (settle_q == CAL_SETTLE_LAST) begin
          band_d = above_s[1] ? band_q : trial;
          cal_req_d = 1'b1; cal_st_d = CAL_SEND;
          if (bit_idx_q == 3'h0) begin
            final_d = 1'b1;
            cal_word_d = {band_to_payload(band_d, 1'b0), fwd_low_q};
          end else begin
            bit_idx_d = bit_idx_q - 3'h1;
            cal_word_d = {band_to_payload(band_d | (6'h01 << bit_idx_d), 1'b1), fwd_low_q};
          end
        end
      end
      default: cal_st_d = CAL_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_st_q <= CAL_IDLE; band_q <= 6'h00; bit_idx_q <= 3'h0; settle_q <= 5'h00;
      final_q <= 1'b0; cal_req_q <= 1'b0; cal_word_q <= '0;
    end else begin
      cal_st_q <= cal_st_d; band_q <= band_d; bit_idx_q <= bit_idx_d; settle_q <= settle_d;
      final_q <= final_d; cal_req_q <= cal_req_d; cal_word_q <= cal_word_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [4:0] bits_sent_q;
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) bits_sent_q <= 5'h00;
    else if (!frame_q) bits_sent_q <= 5'h00;
    else if (tick) bits_sent_q <= bits_sent_q + 5'h01;
  end

  property p_pkt_len;
    @(posedge link_clk) disable iff (!rst_n) $fell(frame_q) |-> bits_sent_q == 5'h10;
  endproperty
  a_pkt_len: assert property (p_pkt_len) else $error("link packet not sixteen bits");

  property p_msb_first;
    @(posedge link_clk) disable iff (!rst_n) host_take ##1 (tx_busy_q && tick) |=> data_q == $past(tx_sh_q[15]) && frame_q;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first link bit is not the msb");

  property p_target_gate;
    @(posedge link_clk) disable iff (!rst_n) we_q |-> $past(rx_pkt.target) == TARGET_OSC;
  endproperty
  a_target_gate: assert property (p_target_gate) else $error("packet for other target stored");

  property p_cal_enable;
    @(posedge link_clk) disable iff (!rst_n) (cal_st_q == CAL_IDLE && cal_st_d == CAL_SEND) |-> !dis_s[1];
  endproperty
  a_cal_enable: assert property (p_cal_enable) else $error("calibration started while disabled");

  property p_cal_addr;
    @(posedge link_clk) disable iff (!rst_n) cal_take |-> cal_word_q[6:0] == fwd_low_q;
  endproperty
  a_cal_addr: assert property (p_cal_addr) else $error("calibration packet misaddressed");

  property p_int_trig;
    @(posedge ref_clk) disable iff (!rst_n) (wr_stb && wr_addr == REG_DIV_INT && !frac_s[1]) |=> cal_tog_q != $past(cal_tog_q);
  endproperty
  a_int_trig: assert property (p_int_trig) else $error("integer divider write did not trigger");

  property p_frac_trig;
    @(posedge ref_clk) disable iff (!rst_n) (wr_stb && wr_addr == REG_DIV_FRAC) |=> cal_tog_q != $past(cal_tog_q) == frac_s[1];
  endproperty
  a_frac_trig: assert property (p_frac_trig) else $error("fractional divider trigger wrong");

  property p_no_clobber;
    @(posedge ref_clk) disable iff (!rst_n) (inflight_q && !ack_edge) |=> $stable(stage_q);
  endproperty
  a_no_clobber: assert property (p_no_clobber) else $error("word in flight was overwritten");

  property p_div_out;
    @(posedge link_clk) disable iff (!rst_n) (mem_rdata[2:0] == DIV_CODE_BY2) |=> fund_q && !dbl_q && se_q;
  endproperty
  a_div_out: assert property (p_div_out) else $error("divide by two routing wrong");
endmodule
`default_nettype wire

// ---- tb/ivf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ivf_host_model;
  logic ref_clk;
  logic spi_sclk = 1'b0;
  logic spi_sel_n = 1'b1;
  logic spi_sdi = 1'b0;
  logic spi_sdo;
  // half period of four core cycles keeps each phase past the sync delay
  task automatic xfer(input logic [30:0] f, output logic [23:0] q);
    q = 24'h000000;
    @(posedge ref_clk) #1 spi_sel_n = 1'b0;
    for (int i = 30; i >= 0; i--) begin
      spi_sdi = f[i];
      repeat (4) @(posedge ref_clk);
      if (i < 24) q = {q[22:0], spi_sdo};
      #1 spi_sclk = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 spi_sclk = 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    #1 spi_sel_n = 1'b1;
    // idle data line is not held at the last bit
    spi_sdi = ~spi_sdi;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/ivf_forwarder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ivf_forwarder_tb;
  import ivf_pkg::*;
  logic ref_clk = 0, link_clk = 0, rst_n = 0, fm = 0, seen = 0;
  wire logic sdo, oe, frame, ld, se, tref, dfun, ddbl;
  wire logic [2:0] div;
  logic [15:0] pkt;
  logic [23:0] q;
  int error_cnt = 0, total_checks = 0;
  ivf_host_model ivf_host_model_inst();
  assign ivf_host_model_inst.ref_clk = ref_clk;
  assign ivf_host_model_inst.spi_sdo = sdo;
  ivf_forwarder ivf_forwarder_inst(.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
    .spi_sclk(ivf_host_model_inst.spi_sclk), .spi_sel_n(ivf_host_model_inst.spi_sel_n),
    .spi_sdi(ivf_host_model_inst.spi_sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .frac_mode(fm),
    .vco_above_target(1'b0), .link_frame(frame), .link_data(ld), .out_div_code(div),
    .diff_out_fundamental(dfun), .diff_out_doubled(ddbl),
    .doubled_single_ended_output(se), .calibration_tune_reference(tref));
  always #25 ref_clk = ~ref_clk;
  initial #17 forever #62.5 link_clk = ~link_clk;
  always @(posedge link_clk) if (frame === 1'b1) pkt <= {pkt[14:0], ld};
  always @(posedge tref) seen = 1'b1;
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    ivf_host_model_inst.xfer({1'b0, a, d}, q);
  endtask
  task automatic rd(input logic [5:0] a);
    ivf_host_model_inst.xfer({1'b1, a, 24'h000000}, q);
  endtask
  task automatic t_forward();
    wr(REG_FWD, 24'h000310);
    repeat (40) @(posedge link_clk);
    chk("packet", 24'h000310, {8'h00, pkt});
    chk("div code", 24'h000006, {21'h0, div});
    chk("diff fundamental", 24'h1, {23'h0, dfun});
    chk("diff doubled", 24'h0, {23'h0, ddbl});
    chk("single ended", 24'h1, {23'h0, se});
    rd(REG_FWD);
    chk("forward read", 24'h000000, q);
  endtask
  task automatic t_cal_bad();
    wr(REG_FWD, 24'h000001);
    seen = 1'b0;
    wr(REG_DIV_INT, 24'h000001);
    repeat (400) @(posedge link_clk);
    chk("cal flag bad target", 24'h0, {23'h0, seen});
  endtask
  task automatic t_cal_ok();
    for (int m = 0; m < 2; m++) begin
      #1 fm = m[0];
      wr(REG_FWD, 24'h000000);
      seen = 1'b0;
      wr(m ? REG_DIV_FRAC : REG_DIV_INT, 24'h000001);
      repeat (400) @(posedge link_clk);
      chk("cal flag", 24'h1, {23'h0, seen});
      chk("cal flag end", 24'h0, {23'h0, tref});
    end
    rd(REG_BAND_RB);
    chk("band readback", 24'h00009f, q);
    // rebuild the forwarding word from the readback so the band survives
    wr(REG_FWD, {8'h00, q[7:6], 1'b0, q[4:0], 8'h00});
    repeat (40) @(posedge link_clk);
    chk("band keep packet", 24'h009f00, {8'h00, pkt});
    rd(REG_BAND_RB);
    chk("band kept", 24'h00009f, q);
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    t_forward();
    t_cal_bad();
    t_cal_ok();
    finish_test();
  end
  initial begin
    #600000;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
